// file: hw/usr_edge_det.sv
// Purpose: rising-transition detector for the sampled shift clock pin
// Assumes: pin is synchronous to clk
// Notes: pulse is one clk cycle wide, combinational from level and last sample
`timescale 1ns/1ps
`default_nettype none
module usr_edge_det (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic level,
    output logic rise
);

    typedef struct packed {
        logic prev;
    } usr_edge_state_t;

    usr_edge_state_t st_r;
    usr_edge_state_t st_nxt;

    // remember last level so only a low-to-high change counts
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.prev = level;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r.prev <= level; // follow the pin so its idle level never looks like an edge
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rise = level & ~st_r.prev;

endmodule // usr_edge_det
`default_nettype wire

// file: hw/usr_fifo.sv
// Purpose: small valid/ready FIFO carrying captured stage words
// Assumes: single clock, synchronous reset
// Notes: depth must be a power of two, at least 2
`timescale 1ns/1ps
`default_nettype none
module usr_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = usr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    // refused at elaboration: the pointers wrap by overflow only for powers of two
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_depth
        $error("usr_fifo: depth must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic not_full;
        logic not_empty;
        logic [WIDTH-1:0] head;
    } usr_fifo_state_t;

    usr_fifo_state_t st_r;
    usr_fifo_state_t st_nxt;
    logic push;
    logic pop;

    assign in_ready = st_r.not_full;
    assign out_valid = st_r.not_empty;
    assign out_data = st_r.head;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // write at tail, read at head; count tracks both so full and empty are exact
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wr_ptr] = in_data;
            st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
        end
        case ({push, pop})
            2'b10: st_nxt.count = st_r.count + 1'b1;
            2'b01: st_nxt.count = st_r.count - 1'b1;
            default: st_nxt.count = st_r.count;
        endcase
        // flags and head are registered so every output leaves a flip-flop
        st_nxt.not_full = (st_nxt.count != DEPTH[AW:0]);
        st_nxt.not_empty = (st_nxt.count != '0);
        st_nxt.head = st_nxt.mem[st_nxt.rd_ptr];
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.not_full <= 1'b1; // an empty buffer takes a word at once
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    a_fifo_bound: assert property (@(posedge clk) disable iff (sys_rst)
        st_r.count <= DEPTH)
        else $error("fifo count above depth");

endmodule // usr_fifo
`default_nettype wire

// file: hw/usr_pkg.sv
// Purpose: shared constants and types of the four-stage universal shift register
// Assumes: one 40 MHz clock, synchronous active-high sys_rst
// Notes: stage 0 is the first stage, stage 3 the last
// Operation
// - clear low forces all four stages low, overriding everything else
// - both selects high: rising edge loads parallel inputs, serial inputs ignored
// - low select only: first stage takes right-serial input, others take predecessor
// - high select only: last stage takes left-serial input, others take successor
// - both selects low: all stages hold as if clock gated off
// - apart from clear, stages change only on a low-to-high shift clock transition
// - exactly four stages, each on its own output, updated after capturing edge
`default_nettype none
package usr_pkg;

    localparam int STAGES = 4;
    localparam logic [3:0] STAGE_RST = 4'h0;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_PERIOD_NS = 25;

    // bit 0 is mode_sel_low, bit 1 is mode_sel_high
    typedef enum logic [1:0] {
        USR_MODE_HOLD = 2'b00,
        USR_MODE_SHR = 2'b01,
        USR_MODE_SHL = 2'b10,
        USR_MODE_LOAD = 2'b11
    } usr_mode_t;

    // inputs that are taken together at a capturing edge
    typedef struct packed {
        logic ser_right;
        logic ser_left;
        logic [3:0] par;
    } usr_data_in_t;

    // stage state of the top module; the edge detector and FIFO hold their own
    typedef struct packed {
        logic [3:0] stages;
    } usr_state_t;

    // next stage contents for a capturing edge in the given mode
    function automatic logic [3:0] usr_next_stages(
        input usr_mode_t mode,
        input logic [3:0] cur,
        input usr_data_in_t din
    );
        logic [3:0] nxt;
        nxt = cur;
        case (mode)
            USR_MODE_LOAD: nxt = din.par;
            USR_MODE_SHR: nxt = {cur[2:0], din.ser_right};
            USR_MODE_SHL: nxt = {din.ser_left, cur[3:1]};
            USR_MODE_HOLD: nxt = cur;
            default: nxt = cur;
        endcase
        return nxt;
    endfunction

endpackage
`default_nettype wire

// file: hw/usr_shift_top.sv
// Purpose: four-stage universal shift register with load, shift right, shift left, hold
// Assumes: all pins synchronous to clk; shift_clk is a sampled level, not a clock
// Notes: each applied edge pushes the new stage word into a small FIFO; while
//        that FIFO is full, edge_ready is low and shift clock edges are ignored
//        clear is sampled like every other pin, so it acts one clk edge late;
//        a shift clock pulse shorter than one clk period can be missed
`timescale 1ns/1ps
`default_nettype none
module usr_shift_top #(
    parameter int STAGES = usr_pkg::STAGES,
    parameter int FIFO_DEPTH = usr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clear_n,
    input wire logic shift_clk,
    input wire logic mode_sel_low,
    input wire logic mode_sel_high,
    input wire logic ser_right_in,
    input wire logic ser_left_in,
    input wire logic [3:0] par_in,
    output logic stage_out_first,
    output logic stage_out_second,
    output logic stage_out_third,
    output logic stage_out_last,
    output logic edge_ready,
    output logic [3:0] word_data,
    output logic word_valid,
    input wire logic word_ready
);

    // the mode decode and shift wiring serve exactly four stages
    if (STAGES != 4)
    begin : g_bad_stages
        $error("usr_shift_top: only four stages are supported");
    end

    usr_pkg::usr_state_t st_r;
    usr_pkg::usr_state_t st_nxt;
    usr_pkg::usr_mode_t mode;
    usr_pkg::usr_data_in_t din;
    logic clk_rise;
    logic fifo_ready;
    logic apply;

    usr_edge_det u_edge (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(shift_clk),
        .rise(clk_rise)
    );

    // mode is sampled at the detected edge; selects settled while clock high
    assign mode = usr_pkg::usr_mode_t'({mode_sel_high, mode_sel_low});
    assign din = '{ser_right: ser_right_in, ser_left: ser_left_in, par: par_in};

    // hold mode is excluded so it never fills the FIFO with repeated words
    assign apply = clear_n & clk_rise & fifo_ready & (mode != usr_pkg::USR_MODE_HOLD);

    // clear has priority over every mode; other changes need a capturing edge
    always_comb
    begin
        st_nxt = st_r;
        if (!clear_n)
        begin
            st_nxt.stages = usr_pkg::STAGE_RST;
        end
        else if (apply)
        begin
            st_nxt.stages = usr_pkg::usr_next_stages(mode, st_r.stages, din);
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r.stages <= usr_pkg::STAGE_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // each stage drives its own output straight from its flip-flop
    assign stage_out_first = st_r.stages[0];
    assign stage_out_second = st_r.stages[1];
    assign stage_out_third = st_r.stages[2];
    assign stage_out_last = st_r.stages[3];

    // stall source: a full FIFO makes edges be ignored rather than dropping words
    usr_fifo #(
        .WIDTH(4),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(apply),
        .in_ready(fifo_ready),
        .in_data(st_nxt.stages),
        .out_valid(word_valid),
        .out_ready(word_ready),
        .out_data(word_data)
    );

    assign edge_ready = fifo_ready;

    // helper signals for the checks below
    logic load_edge;
    logic shr_edge;
    logic shl_edge;
    assign load_edge = apply && mode == usr_pkg::USR_MODE_LOAD;
    assign shr_edge = apply && mode == usr_pkg::USR_MODE_SHR;
    assign shl_edge = apply && mode == usr_pkg::USR_MODE_SHL;

    // pins as one word, so the checks below look at what the outside sees
    logic [3:0] pin_stages;
    assign pin_stages = {stage_out_last, stage_out_third, stage_out_second, stage_out_first};

    sequence s_clear_held;
        !clear_n ##1 !clear_n;
    endsequence

    sequence s_release_idle;
        clear_n && st_r.stages == 4'h0 && !apply;
    endsequence

    // clear seen low and then released at the next sample
    sequence s_clear_release;
        !clear_n ##1 clear_n;
    endsequence

    // shift clock pin high at two samples in a row, so no edge in between
    sequence s_clk_steady_high;
        clear_n && shift_clk && $past(shift_clk);
    endsequence

    // shift clock pin low now, so this sample cannot be a capturing edge
    sequence s_clk_steady_low;
        clear_n && !shift_clk;
    endsequence

    // an edge that meets a full buffer and must be dropped
    sequence s_refused_edge;
        clear_n && clk_rise && !edge_ready;
    endsequence

    // a word waits at the head while the consumer holds off
    sequence s_word_stalled;
        word_valid && !word_ready;
    endsequence

    a_clear_zero: assert property (
        @(posedge clk) disable iff (sys_rst)
        !clear_n |=> st_r.stages == 4'h0)
        else $error("clear did not zero the stages");

    a_clear_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_clear_held |=> {stage_out_first, stage_out_second,
            stage_out_third, stage_out_last} == 4'h0)
        else $error("outputs not low under held clear");

    a_load_parallel: assert property (
        @(posedge clk) disable iff (sys_rst)
        load_edge |=> st_r.stages == $past(par_in))
        else $error("parallel load mismatch");

    a_shift_right: assert property (
        @(posedge clk) disable iff (sys_rst)
        shr_edge |=> st_r.stages == {$past(st_r.stages[2:0]), $past(ser_right_in)})
        else $error("shift right mismatch");

    a_shift_left: assert property (
        @(posedge clk) disable iff (sys_rst)
        shl_edge |=> st_r.stages == {$past(ser_left_in), $past(st_r.stages[3:1])})
        else $error("shift left mismatch");

    a_hold_mode: assert property (
        @(posedge clk) disable iff (sys_rst)
        clear_n && mode == usr_pkg::USR_MODE_HOLD |=> $stable(st_r.stages))
        else $error("stages changed in hold mode");

    a_no_edge_hold: assert property (
        @(posedge clk) disable iff (sys_rst)
        clear_n && !(shift_clk && !$past(shift_clk)) |=> $stable(st_r.stages))
        else $error("stages changed without a rising edge");

    a_last_output: assert property (
        @(posedge clk) disable iff (sys_rst)
        load_edge |=> stage_out_last == $past(par_in[3])
            && stage_out_first == $past(par_in[0]))
        else $error("loaded data not on outputs after edge");

    a_release_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_release_idle |=> st_r.stages == 4'h0)
        else $error("stages left zero without load or shift");

    a_word_pushed: assert property (
        @(posedge clk) disable iff (sys_rst)
        apply |=> word_valid)
        else $error("applied edge left no word in the buffer");

    // clear seen on the pins, and it never feeds the buffer
    a_clear_pins: assert property (
        @(posedge clk) disable iff (sys_rst)
        !clear_n |=> pin_stages == usr_pkg::STAGE_RST)
        else $error("clear did not drive the pins low");

    a_clear_no_word: assert property (
        @(posedge clk) disable iff (sys_rst)
        !clear_n && !word_valid |=> !word_valid)
        else $error("clear pushed a word");

    a_release_wait: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_clear_release ##0 !apply |=> pin_stages == usr_pkg::STAGE_RST)
        else $error("stages moved right after clear release");

    // a steady shift clock level never moves the stages
    a_steady_high: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_clk_steady_high |=> $stable(st_r.stages))
        else $error("stages moved with shift clock held high");

    a_steady_low: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_clk_steady_low |=> $stable(st_r.stages))
        else $error("stages moved with shift clock held low");

    a_refused_edge: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_refused_edge |=> $stable(st_r.stages))
        else $error("edge applied against a full buffer");

    a_hold_no_word: assert property (
        @(posedge clk) disable iff (sys_rst)
        clear_n && mode == usr_pkg::USR_MODE_HOLD && !word_valid |=> !word_valid)
        else $error("hold mode pushed a word");

    // serial entry points of both shift directions
    a_right_entry: assert property (
        @(posedge clk) disable iff (sys_rst)
        shr_edge |=> stage_out_first == $past(ser_right_in))
        else $error("first stage missed the right serial input");

    a_left_entry: assert property (
        @(posedge clk) disable iff (sys_rst)
        shl_edge |=> stage_out_last == $past(ser_left_in))
        else $error("last stage missed the left serial input");

    // the word stream: an empty buffer shows the new word at once
    a_word_first: assert property (
        @(posedge clk) disable iff (sys_rst)
        apply && !word_valid |=> word_data == st_r.stages)
        else $error("head word differs from the new stages");

    a_load_word: assert property (
        @(posedge clk) disable iff (sys_rst)
        load_edge && !word_valid |=> word_data == $past(par_in))
        else $error("loaded word not at the buffer head");

    a_word_stands: assert property (
        @(posedge clk) disable iff (sys_rst)
        s_word_stalled |=> word_valid && $stable(word_data))
        else $error("stalled word did not stand");

    a_full_nonempty: assert property (
        @(posedge clk) disable iff (sys_rst)
        !edge_ready |-> word_valid)
        else $error("buffer full but no word offered");

    a_pop_frees: assert property (
        @(posedge clk) disable iff (sys_rst)
        !edge_ready && word_ready |=> edge_ready)
        else $error("pop from a full buffer left it full");

    // a fresh reset must leave an empty buffer that accepts edges
    a_reset_state: assert property (
        @(posedge clk)
        $fell(sys_rst) |-> pin_stages == usr_pkg::STAGE_RST && edge_ready && !word_valid)
        else $error("state after reset release is wrong");

    // per-stage checks of load and both shift directions
    for (genvar i = 0; i < 4; i++)
    begin : g_stage_chk
        a_stage_load: assert property (
            @(posedge clk) disable iff (sys_rst)
            load_edge |=> st_r.stages[i] == $past(par_in[i]))
            else $error("stage did not take its parallel input");

        if (i > 0)
        begin : g_right
            a_stage_right: assert property (
                @(posedge clk) disable iff (sys_rst)
                shr_edge |=> st_r.stages[i] == $past(st_r.stages[i-1]))
                else $error("stage did not take its predecessor");
        end

        if (i < 3)
        begin : g_left
            a_stage_left: assert property (
                @(posedge clk) disable iff (sys_rst)
                shl_edge |=> st_r.stages[i] == $past(st_r.stages[i+1]))
                else $error("stage did not take its successor");
        end
    end

endmodule // usr_shift_top
`default_nettype wire

// file: test/test_universal_bidir_shift_register.sv
// Purpose: self-checking bench of the four-stage universal shift register
// Assumes: 40 MHz clk, inputs driven by non-blocking assignment at rising edges
// Notes: driver notes pushed words in a queue, a monitor checks pops in order
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module test_universal_bidir_shift_register;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clear_n = 1'b1;
    logic shift_clk = 1'b1;
    logic mode_sel_low = 1'b0;
    logic mode_sel_high = 1'b0;
    logic ser_right_in = 1'b0;
    logic ser_left_in = 1'b0;
    logic [3:0] par_in = 4'h0;
    logic stall = 1'b0;
    logic stage_out_first, stage_out_second, stage_out_third, stage_out_last;
    logic edge_ready, word_valid, word_ready;
    logic [3:0] word_data;
    logic [3:0] model_q = 4'h0;
    logic [3:0] exp_w;
    logic [3:0] q[$];
    int errors = 0;
    int num_checks = 0;
    wire [3:0] stages = {stage_out_last, stage_out_third, stage_out_second, stage_out_first};

    usr_shift_top i_usr_shift_top (.clk(clk), .sys_rst(sys_rst), .clear_n(clear_n),
        .shift_clk(shift_clk), .mode_sel_low(mode_sel_low), .mode_sel_high(mode_sel_high),
        .ser_right_in(ser_right_in), .ser_left_in(ser_left_in), .par_in(par_in),
        .stage_out_first(stage_out_first), .stage_out_second(stage_out_second),
        .stage_out_third(stage_out_third), .stage_out_last(stage_out_last),
        .edge_ready(edge_ready), .word_data(word_data), .word_valid(word_valid),
        .word_ready(word_ready));
    usr_sink_model i_usr_sink_model (.clk(clk), .sys_rst(sys_rst), .stall(stall),
        .word_ready(word_ready));

    // free-running 25 ns clock
    initial
    begin
        forever #(usr_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // reference of one capturing edge, kept apart from the design's own helper
    function automatic logic [3:0] exp_next(input logic [1:0] m, input logic [3:0] c,
        input logic [3:0] p, input logic sr, input logic sl);
        case (m)
            2'b11: return p;
            2'b01: return {c[2:0], sr};
            2'b10: return {sl, c[3:1]};
            default: return c;
        endcase
    endfunction

    // one shift clock pulse; mode moves only while the shift clock is high
    task automatic apply(input logic [1:0] m, input logic [3:0] p, input logic sr,
        input logic sl);
        logic ok;
        @(posedge clk);
        mode_sel_high <= m[1];
        mode_sel_low <= m[0];
        par_in <= p;
        ser_right_in <= sr;
        ser_left_in <= sl;
        @(posedge clk);
        shift_clk <= 1'b0;
        @(posedge clk);
        shift_clk <= 1'b1;
        #1;
        ok = (edge_ready === 1'b1) && (clear_n === 1'b1) && (m != 2'b00);
        `CHK(stages, model_q)
        if (ok)
        begin
            model_q = exp_next(m, model_q, p, sr, sl);
            q.push_back(model_q);
        end
        @(posedge clk);
        #1;
        `CHK(stages, model_q)
    endtask

    // each popped word must be the oldest noted one
    always @(posedge clk)
    begin
        if (!sys_rst && word_valid === 1'b1 && word_ready === 1'b1)
        begin
            exp_w = (q.size() > 0) ? q.pop_front() : ~word_data;
            `CHK(word_data, exp_w)
        end
    end

    // hang guard
    initial
    begin
        #1000000;
        errors++;
        conclude();
    end

    initial
    begin
        void'($urandom(32'h53e6));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        // every mode once, then a steady-level stretch with load selected
        for (int m = 0; m < 4; m++)
            apply(m[1:0], 4'h9, 1'b1, 1'b0);
        apply(2'b11, 4'ha, 1'b0, 1'b1);
        repeat (4) @(posedge clk);
        #1;
        `CHK(stages, model_q)
        // clear beats a load edge, then hold after release keeps zero
        @(posedge clk);
        clear_n <= 1'b0;
        model_q = 4'h0;
        @(posedge clk);
        #1;
        `CHK(stages, 4'h0)
        apply(2'b11, 4'hf, 1'b1, 1'b1);
        @(posedge clk);
        clear_n <= 1'b1;
        apply(2'b00, 4'hf, 1'b1, 1'b1);
        apply(2'b01, 4'h0, 1'b1, 1'b0);
        // stalled consumer: buffer fills and the fifth edge is refused
        stall <= 1'b1;
        repeat (5) apply(2'b11, 4'($urandom), 1'b0, 1'b0);
        `CHK(edge_ready, 1'b0)
        stall <= 1'b0;
        // random traffic with a random stalling consumer
        repeat (60)
        begin
            stall <= 1'($urandom);
            apply(2'($urandom), 4'($urandom), 1'($urandom), 1'($urandom));
        end
        stall <= 1'b0;
        for (int i = 0; i < 100 && q.size() != 0; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
        `CHK(q.size(), 0)
        `CHK(word_valid, 1'b0)
        conclude();
    end
endmodule // test_universal_bidir_shift_register
`default_nettype wire

// file: test/usr_sink_model.sv
// Purpose: consumer of the stage-word stream, able to take words at once or stall
// Assumes: one clock, synchronous active-high sys_rst
// Notes: ready is registered, so a stall request lands one edge later
`timescale 1ns/1ps
`default_nettype none
module usr_sink_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic stall,
    output var logic word_ready
);
    // registered ready, like a real consumer that decides a cycle ahead
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            word_ready <= 1'b0;
        else
            word_ready <= !stall;
    end
endmodule // usr_sink_model
`default_nettype wire
